// file: hw/spics_regs.svh
`ifndef SPICS_REGS_SVH
`define SPICS_REGS_SVH
// ****************
// constants
// ****************
`define SPICS_WORD_BITS       16
`define SPICS_DIV_BITS        8
`define SPICS_CNT_BITS        6
`define SPICS_MODE_NODELAY    2'h2
`define SPICS_MODE_HALFDELAY  2'h3
`define SPICS_DIR_MASTER      4'hC
`define SPICS_DIR_SLAVE       4'h0
`define SPICS_SLAVE_DIV       8'h01
`define SPICS_MASTER_MIN_HALF 12
`define SPICS_SLAVE_MIN_HALF  32
`define SPICS_SLAVE_TRISTATE  3
`define SPICS_CLOCK_OUTPUT_DIVIDE_FACTOR_NONE     2'h0
`endif

// file: hw/spics_pkg.sv
package spics_pkg;
	// ****************
	// types
	// ****************
	typedef struct packed {
		logic [1:0] clock_stop_mode_field;
		logic       transmit_clock_polarity;
		logic [7:0] clock_divide_value;
		logic       rate_gen_clock_source_select;
		logic       transmit_clock_direction;
		logic       receive_clock_direction;
		logic       transmit_frame_direction;
		logic       receive_frame_direction;
		logic       transmit_frame_polarity;
		logic       receive_frame_polarity;
		logic [1:0] clock_output_divide_factor;
	} spics_cfg_type;

	typedef enum logic [2:0] {
		SPICS_IDLE  = 3'b000,
		SPICS_LEAD  = 3'b001,
		SPICS_SHIFT = 3'b010,
		SPICS_TAIL  = 3'b011,
		SPICS_DONE  = 3'b100
	} spics_state_type;
endpackage

// file: hw/spics_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
`include "spics_regs.svh"
// phase timer: counts low or high phase of the shift clock in mclk cycles (one mclk = 2H)
module spics_clkgen (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	// control
	input  wire logic                        run,
	input  wire logic [`SPICS_DIV_BITS-1:0]  div,
	input  wire logic                        phase_high,
	// result
	output logic                             phase_end
);
	logic [`SPICS_DIV_BITS:0] cnt;
	logic [`SPICS_DIV_BITS:0] len_low;
	logic [`SPICS_DIV_BITS:0] len_high;
	logic [`SPICS_DIV_BITS:0] period;

	// period = (1+div) cycles; odd period split with the extra cycle high
	assign period   = {1'b0, div} + 9'h001;
	assign len_low  = (div == 8'h00) ? 9'h001 : {1'b0, period[8:1]};
	assign len_high = (div == 8'h00) ? 9'h001 : period - {1'b0, period[8:1]};
	assign phase_end = run && (cnt == ((phase_high ? len_high : len_low) - 9'h001));

	always_ff @(posedge mclk) begin
		if (sys_rst || !run || phase_end) begin
			cnt <= 9'h000;
		end else begin
			cnt <= cnt + 9'h001;
		end
	end
endmodule
`default_nettype wire

// file: hw/spics_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage level synchroniser for pins driven by an external master
module spics_sync (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// level
	input  wire logic din,
	output logic      dout
);
	logic meta;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule
`default_nettype wire

// file: hw/spics_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spics_regs.svh"
module spics_top (
	// clock and reset
	input  wire logic                           mclk,
	input  wire logic                           sys_rst,
	// configuration
	input  wire spics_pkg::spics_cfg_type       cfg,
	input  wire logic                           master_mode,
	// word interface
	input  wire logic                           tx_valid,
	input  wire logic [`SPICS_WORD_BITS-1:0]    tx_data,
	output logic                                tx_ready,
	output logic                                rx_valid,
	output logic [`SPICS_WORD_BITS-1:0]         rx_data,
	output logic                                busy,
	output logic                                cfg_error,
	// shift clock pin
	input  wire logic                           shift_clock_pin_in,
	output logic                                shift_clock_pin_out,
	output logic                                shift_clock_pin_oe_n,
	// select pin
	input  wire logic                           slave_select_pin_in,
	output logic                                slave_select_pin_out,
	output logic                                slave_select_pin_oe_n,
	// receive frame pin (slave select copy)
	input  wire logic                           receive_frame_pin,
	// data pins
	output logic                                serial_data_out_pin,
	output logic                                serial_data_out_pin_oe_n,
	input  wire logic                           serial_data_in_pin
);
	import spics_pkg::*;

	// ****************
	// configuration checks
	// ****************
	logic half_delay;
	logic mode_ok;
	logic [3:0] dirs;
	assign half_delay = (cfg.clock_stop_mode_field == `SPICS_MODE_HALFDELAY);
	assign dirs = {cfg.transmit_clock_direction, cfg.transmit_frame_direction,
		cfg.receive_clock_direction, cfg.receive_frame_direction};
	// only idle-low clock-stop modes are supported; others hold the port idle
	assign mode_ok = cfg.clock_stop_mode_field[1] && !cfg.transmit_clock_polarity
		&& cfg.transmit_frame_polarity && cfg.receive_frame_polarity
		&& (cfg.clock_output_divide_factor == `SPICS_CLOCK_OUTPUT_DIVIDE_FACTOR_NONE || 1'b1)
		&& (master_mode ? (dirs == `SPICS_DIR_MASTER
			&& cfg.clock_divide_value >= 8'(`SPICS_MASTER_MIN_HALF / 2 - 1))
		: (dirs == `SPICS_DIR_SLAVE
			&& cfg.rate_gen_clock_source_select
			&& cfg.clock_divide_value == `SPICS_SLAVE_DIV));
	assign cfg_error = !mode_ok;

	// ****************
	// slave pin synchronisers
	// ****************
	logic sclk_s;
	logic ssel_s;
	logic rsel_s;
	spics_sync u_sync_clk (.mclk(mclk), .sys_rst(sys_rst), .din(shift_clock_pin_in), .dout(sclk_s));
	spics_sync u_sync_sel (.mclk(mclk), .sys_rst(sys_rst), .din(slave_select_pin_in), .dout(ssel_s));
	spics_sync u_sync_rfs (.mclk(mclk), .sys_rst(sys_rst), .din(receive_frame_pin), .dout(rsel_s));
	logic sclk_d;
	logic frame_in;
	logic frame_d;
	// select is active low on both frame pins; internal frame is active high
	assign frame_in = !ssel_s && !rsel_s;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sclk_d  <= 1'b0;
			frame_d <= 1'b0;
		end else begin
			sclk_d  <= sclk_s;
			frame_d <= frame_in;
		end
	end
	logic s_rise;
	logic s_fall;
	assign s_rise = sclk_s && !sclk_d;
	assign s_fall = !sclk_s && sclk_d;

	// ****************
	// master sequencer
	// ****************
	spics_state_type state;
	spics_state_type next_state;
	logic phase_high;
	logic phase_end;
	logic [`SPICS_CNT_BITS-1:0] edges;
	logic lead_high;
	spics_clkgen u_clkgen (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.run       (state != SPICS_IDLE && state != SPICS_DONE),
		.div       (cfg.clock_divide_value),
		.phase_high(phase_high),
		.phase_end (phase_end)
	);

	always_comb begin
		next_state = state;
		case (state)
			SPICS_IDLE: begin
				if (master_mode && mode_ok && tx_valid) begin
					next_state = SPICS_LEAD;
				end
			end
			SPICS_LEAD: begin
				// no-delay: one low phase; half-delay: low then high phase
				if (phase_end && (!half_delay || lead_high)) begin
					next_state = SPICS_SHIFT;
				end
			end
			SPICS_SHIFT: begin
				if (phase_end && phase_high && edges == 6'(`SPICS_WORD_BITS - 1)) begin
					next_state = SPICS_TAIL;
				end
			end
			SPICS_TAIL: begin
				// no-delay holds a full period, half-delay one low phase
				if (phase_end && (half_delay || phase_high)) begin
					next_state = SPICS_DONE;
				end
			end
			default: begin
				next_state = SPICS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= SPICS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || state == SPICS_IDLE) begin
			phase_high <= 1'b0;
			lead_high  <= 1'b0;
			edges      <= 6'h00;
		end else if (phase_end) begin
			phase_high <= !phase_high;
			if (state == SPICS_LEAD) begin
				// the lead supplies the low phase before the first rise, so shifting opens high
				lead_high  <= 1'b1;
				phase_high <= 1'b1;
			end
			if (state == SPICS_SHIFT && phase_high) begin
				edges <= edges + 6'h01;
			end
			if (state == SPICS_SHIFT && next_state == SPICS_TAIL) begin
				phase_high <= 1'b0;
			end
		end
	end

	// shift clock toggles only inside the bit phase of a master frame
	logic m_clk;
	logic m_rise;
	logic m_fall;
	assign m_clk  = (state == SPICS_SHIFT) && phase_high;
	assign m_rise = phase_end && (((state == SPICS_SHIFT) && !phase_high)
		|| (state == SPICS_LEAD && next_state == SPICS_SHIFT));
	assign m_fall = (state == SPICS_SHIFT) && phase_end && phase_high;

	// ****************
	// shift register, common to both roles
	// ****************
	logic active;
	logic drv_edge;
	logic smp_edge;
	logic [`SPICS_WORD_BITS-1:0] tx_sh;
	logic [`SPICS_WORD_BITS-1:0] rx_sh;
	logic [`SPICS_CNT_BITS-1:0] bits;
	logic drive_en;
	logic load;
	assign active = master_mode ? (state != SPICS_IDLE && state != SPICS_DONE) : (frame_d && mode_ok);
	// edge roles swap between the two delay modes
	assign drv_edge = master_mode ? (half_delay ? m_fall : m_rise)
		: (half_delay ? s_fall : s_rise);
	assign smp_edge = master_mode ? (half_delay ? m_rise : m_fall)
		: (half_delay ? s_rise : s_fall);
	assign load = master_mode ? (state == SPICS_IDLE && next_state == SPICS_LEAD)
		: (frame_in && !frame_d && mode_ok);
	assign tx_ready = master_mode ? (state == SPICS_IDLE && mode_ok) : !frame_d;
	assign busy = active;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tx_sh <= '0;
		end else if (load) begin
			tx_sh <= tx_valid ? tx_data : '0;
		end else if (drv_edge && (half_delay || bits != 6'h00)) begin
			// first bit is presented at select in no-delay; shift after each later drive edge
			tx_sh <= {tx_sh[`SPICS_WORD_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || load) begin
			bits <= 6'h00;
		end else if (smp_edge && active) begin
			bits <= bits + 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_sh    <= '0;
			rx_data  <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (smp_edge && active) begin
				rx_sh <= {rx_sh[`SPICS_WORD_BITS-2:0], serial_data_in_pin};
				if (bits == 6'(`SPICS_WORD_BITS - 1)) begin
					rx_data  <= {rx_sh[`SPICS_WORD_BITS-2:0], serial_data_in_pin};
					rx_valid <= 1'b1;
				end
			end
		end
	end

	// data driver: half-delay presents first bit after the lead low phase,
	// no-delay from select; master floats at the tail high phase in no-delay, after the tail in half-delay; slave at select release
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			drive_en <= 1'b0;
		end else if (master_mode) begin
			drive_en <= (state == SPICS_LEAD && (!half_delay || lead_high))
				|| state == SPICS_SHIFT
				|| (state == SPICS_TAIL && !phase_high);
		end else begin
			drive_en <= frame_in && mode_ok;
		end
	end

	// ****************
	// pins
	// ****************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			shift_clock_pin_out  <= 1'b0;
			slave_select_pin_out <= 1'b1;
			serial_data_out_pin  <= 1'b0;
		end else begin
			shift_clock_pin_out  <= master_mode && m_clk;
			slave_select_pin_out <= !(master_mode && active);
			serial_data_out_pin  <= tx_sh[`SPICS_WORD_BITS-1];
		end
	end
	assign shift_clock_pin_oe_n     = !master_mode;
	assign slave_select_pin_oe_n    = !master_mode;
	assign serial_data_out_pin_oe_n = !drive_en;

	// ****************
	// assertions
	// ****************
	sequence s_frame_start;
		master_mode && state == SPICS_IDLE && next_state == SPICS_LEAD;
	endsequence
	property p_clk_rest;
		@(posedge mclk) disable iff (sys_rst)
		(state == SPICS_IDLE) |=> !shift_clock_pin_out;
	endproperty
	a_clk_rest: assert property (p_clk_rest) else $error("shift clock not low at rest");
	property p_sel_lead;
		@(posedge mclk) disable iff (sys_rst)
		s_frame_start |=> ##2 !slave_select_pin_out;
	endproperty
	a_sel_lead: assert property (p_sel_lead) else $error("select not asserted at frame start");
	property p_period;
		@(posedge mclk) disable iff (sys_rst)
		(m_rise && master_mode) |-> ##[1:256] m_fall;
	endproperty
	a_period: assert property (p_period) else $error("high phase too long");
	property p_float_slave;
		@(posedge mclk) disable iff (sys_rst)
		(!master_mode && !frame_in) |=> serial_data_out_pin_oe_n;
	endproperty
	a_float_slave: assert property (p_float_slave) else $error("slave kept driving");
	property p_rx_word;
		@(posedge mclk) disable iff (sys_rst)
		rx_valid |-> $past(smp_edge);
	endproperty
	a_rx_word: assert property (p_rx_word) else $error("word without sample edge");
	property p_dir_master;
		@(posedge mclk) disable iff (sys_rst)
		(master_mode && state != SPICS_IDLE) |-> dirs == `SPICS_DIR_MASTER;
	endproperty
	a_dir_master: assert property (p_dir_master) else $error("master frame with bad directions");
	property p_slave_div;
		@(posedge mclk) disable iff (sys_rst)
		(!master_mode && active) |-> cfg.clock_divide_value == `SPICS_SLAVE_DIV;
	endproperty
	a_slave_div: assert property (p_slave_div) else $error("slave without half rate clock");
	property p_float_master;
		@(posedge mclk) disable iff (sys_rst)
		(master_mode && state == SPICS_DONE) |=> serial_data_out_pin_oe_n;
	endproperty
	a_float_master: assert property (p_float_master) else $error("master kept driving");
endmodule
`default_nettype wire

// file: dv/spics_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// external spi slave peripheral, clock idling low
// ****************
module spics_partner (
	// pins
	input  wire logic        sck,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	output logic             miso,
	// control and capture
	input  wire logic        half,
	input  wire logic [15:0] word,
	output logic [15:0]      got
);
	int idx;
	initial begin
		miso = 1'h0;
		got  = 16'h0000;
		idx  = 15;
	end
	always @(negedge ss_n) begin
		idx = 15;
		if (half) begin
			miso = word[15];
			idx  = 14;
		end
	end
	// released line shows the inverse so a stale bit never passes for a good one
	always @(posedge ss_n) miso = ~miso;
	always @(posedge sck) begin
		if (!ss_n && !half && idx >= 0) begin
			miso = word[idx];
			idx  = idx - 1;
		end else if (!ss_n && half) begin
			got = {got[14:0], mosi};
		end
	end
	always @(negedge sck) begin
		if (!ss_n && !half) begin
			got = {got[14:0], mosi};
		end else if (!ss_n && half && idx >= 0) begin
			miso = word[idx];
			idx  = idx - 1;
		end
	end
endmodule
`default_nettype wire

// file: dv/spics_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spics_top_tb import spics_pkg::*;;
	logic          mclk, sys_rst, master_mode, tx_valid, tb_sck, tb_ss, tb_din, half, rx_seen, sck_q, ss_q;
	spics_cfg_type cfg;
	logic [15:0]   tx_data, rx_data, p_word, p_got;
	logic          tx_ready, rx_valid, busy, cfg_error, sck_o, sck_oe_n, ss_o, ss_oe_n, dout, dout_oe_n, p_miso;
	int            run, lead, lo_len, hi_len, tail, nrise, err_count, comparisons, cycles;
	wire logic     sck_w  = sck_oe_n ? tb_sck : sck_o;
	wire logic     ss_w   = ss_oe_n ? tb_ss : ss_o;
	wire logic     mosi_w = dout ^ dout_oe_n;
	wire logic     din_w  = master_mode ? p_miso : tb_din;

	spics_top i_spics_top (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .master_mode(master_mode),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.busy(busy), .cfg_error(cfg_error), .shift_clock_pin_in(sck_w), .shift_clock_pin_out(sck_o),
		.shift_clock_pin_oe_n(sck_oe_n), .slave_select_pin_in(ss_w), .slave_select_pin_out(ss_o),
		.slave_select_pin_oe_n(ss_oe_n), .receive_frame_pin(tb_ss), .serial_data_out_pin(dout),
		.serial_data_out_pin_oe_n(dout_oe_n), .serial_data_in_pin(din_w));
	spics_partner i_spics_partner (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(p_miso), .half(half),
		.word(p_word), .got(p_got));

	always #20 mclk = ~mclk;

	// ****************
	// pin timing monitor: mclk cycles between edges of clock and select
	// ****************
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			end_of_test();
		end
		if (rx_valid === 1'h1) rx_seen = 1'h1;
		if (sck_w !== sck_q || ss_w !== ss_q) begin
			if (sck_w && !sck_q) begin
				if (nrise == 0) lead = run;
				else lo_len = run;
				nrise++;
			end
			if (!sck_w && sck_q) hi_len = run;
			if (ss_w && !ss_q) tail = run;
			if (!ss_w && ss_q) nrise = 0;
			run = 1;
		end else run++;
		sck_q = sck_w;
		ss_q = ss_w;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic spics_cfg_type mkcfg(input logic [1:0] mode, input logic [7:0] div, input logic m,
		input logic [1:0] dvf);
		spics_cfg_type c;
		c.clock_stop_mode_field = mode;
		c.transmit_clock_polarity = 1'h0;
		c.clock_divide_value = m ? div : 8'h01;
		c.rate_gen_clock_source_select = 1'h1;
		c.transmit_clock_direction = m;
		c.receive_clock_direction = 1'h0;
		c.transmit_frame_direction = m;
		c.receive_frame_direction = 1'h0;
		c.transmit_frame_polarity = 1'h1;
		c.receive_frame_polarity = 1'h1;
		c.clock_output_divide_factor = dvf;
		return c;
	endfunction

	task automatic end_of_test();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic master_frame(input logic [1:0] mode, input logic [7:0] div, input logic [1:0] dvf,
		input logic [15:0] w);
		int t_len, c_len, d_len, n;
		t_len = div + 1;
		c_len = div[0] ? t_len / 2 : div / 2;
		d_len = t_len - c_len;
		@(negedge mclk);
		master_mode = 1'h1;
		cfg = mkcfg(mode, div, 1'h1, dvf);
		half = mode[0];
		p_word = ~w;
		tx_data = w;
		tx_valid = 1'h1;
		rx_seen = 1'h0;
		n = 0;
		@(posedge mclk);
		while (tx_ready !== 1'h1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		@(negedge mclk);
		tx_valid = 1'h0;
		n = 0;
		while (busy !== 1'h0 && n < 1000) begin
			@(negedge mclk);
			n++;
		end
		repeat (2) @(negedge mclk);
		chk("rx_data", ~w, rx_data);
		chk("rx_valid", 16'h0001, {15'h0000, rx_seen});
		chk("far_word", w, p_got);
		chk("rises", 16'h0010, 16'(nrise));
		chk("low_phase", 16'(c_len), 16'(lo_len));
		chk("high_phase", 16'(d_len), 16'(hi_len));
		chk("period", 16'(t_len), 16'(lo_len + hi_len));
		chk("lead", 16'(mode[0] ? t_len : c_len), 16'(lead));
		chk("tail", 16'(mode[0] ? c_len : t_len), 16'(tail));
		chk("data_oe_n", 16'h0001, {15'h0000, dout_oe_n});
		chk("sck_idle", 16'h0000, {15'h0000, sck_w});
		chk("ss_idle", 16'h0001, {15'h0000, ss_w});
		$display("test master mode %h div %h done", mode, div);
	endtask

	// testbench plays the external master at 16 mclk per period (32H)
	task automatic slave_frame(input logic [1:0] mode, input logic [15:0] w, input logic [15:0] dw);
		logic [15:0] seen;
		@(negedge mclk);
		master_mode = 1'h0;
		cfg = mkcfg(mode, 8'h01, 1'h0, 2'h0);
		tx_data = dw;
		tx_valid = 1'h1;
		rx_seen = 1'h0;
		repeat (8) @(negedge mclk);
		tb_ss = 1'h0;
		if (mode[0]) tb_din = w[15];
		repeat (8) @(negedge mclk);
		for (int i = 15; i >= 0; i--) begin
			tb_sck = 1'h1;
			if (!mode[0]) tb_din = w[i];
			else seen[i] = dout;
			repeat (8) @(negedge mclk);
			tb_sck = 1'h0;
			if (!mode[0]) seen[i] = dout;
			else if (i > 0) tb_din = w[i-1];
			repeat (8) @(negedge mclk);
		end
		tb_ss = 1'h1;
		tb_din = ~tb_din;
		tx_valid = 1'h0;
		repeat (5) @(negedge mclk);
		chk("slave_rx", w, rx_data);
		chk("slave_rx_valid", 16'h0001, {15'h0000, rx_seen});
		chk("slave_tx", dw, seen);
		chk("slave_oe_n", 16'h0001, {15'h0000, dout_oe_n});
		$display("test slave mode %h done", mode);
	endtask

	task automatic refused_modes();
		for (int m = 0; m < 2; m++) begin
			@(negedge mclk);
			master_mode = 1'h1;
			cfg = mkcfg(2'(m), 8'h05, 1'h1, 2'h0);
			tx_valid = 1'h1;
			repeat (20) @(negedge mclk);
			chk("cfg_error", 16'h0001, {15'h0000, cfg_error});
			chk("tx_ready", 16'h0000, {15'h0000, tx_ready});
			chk("busy", 16'h0000, {15'h0000, busy});
			chk("ss_refused", 16'h0001, {15'h0000, ss_w});
			chk("sck_refused", 16'h0000, {15'h0000, sck_w});
			tx_valid = 1'h0;
		end
		$display("test refused modes done");
	endtask

	initial begin
		mclk = 1'h0;
		sys_rst = 1'h1;
		master_mode = 1'h1;
		cfg = mkcfg(2'h2, 8'h05, 1'h1, 2'h0);
		tx_valid = 1'h0;
		tx_data = 16'h0000;
		tb_sck = 1'h0;
		tb_ss = 1'h1;
		tb_din = 1'h0;
		half = 1'h0;
		p_word = 16'h0000;
		rx_seen = 1'h0;
		repeat (5) @(negedge mclk);
		sys_rst = 1'h0;
		chk("reset_ss", 16'h0001, {15'h0000, ss_w});
		chk("reset_sck", 16'h0000, {15'h0000, sck_w});
		master_frame(2'h2, 8'h05, 2'h0, 16'hA5C3);
		master_frame(2'h2, 8'h06, 2'h3, 16'h8001);
		master_frame(2'h3, 8'h06, 2'h0, 16'h7E18);
		master_frame(2'h3, 8'h05, 2'h0, 16'hFFFE);
		slave_frame(2'h2, 16'h9C35, 16'h4AD2);
		slave_frame(2'h3, 16'h1E0F, 16'hC3B4);
		refused_modes();
		end_of_test();
	end
endmodule
`default_nettype wire
